//--- logic/ccs_sequencer.sv
// Command sequencer for a block cipher processor with a Wishbone port.
`default_nettype none
module ccs_sequencer
  import ccs_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [4:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic direct_mode_i,
  input wire logic start_stop_pin_i,
  input wire logic direction_select_pin_i,
  input wire logic host_address_strobe_n_i,
  input wire logic host_data_strobe_n_i,
  input wire logic [63:0] key_m_i,
  input wire logic [63:0] key_e_i,
  input wire logic [63:0] key_d_i,
  output logic primary_port_flag_n_o,
  output logic secondary_port_flag_n_o,
  output logic busy_output_pin_n_o
);
  ccs_core_if cif ();
  ccs_state_t state_ff;
  logic [7:0] cmd_ff;
  logic [7:0] mode_ff;
  logic run_state_bit_ff;
  logic pending_status_bit_ff;
  logic busy_status_bit_ff;
  logic [63:0] encrypt_init_vector_ff;
  logic [63:0] decrypt_init_vector_ff;
  logic [63:0] blk_ff;
  logic [3:0] cnt_ff;
  logic [3:0] dly_ff;
  logic start_ff;
  logic [1:0] key_ff;
  logic dec_ff;
  logic ack_ff;
  logic [31:0] rdat_ff;
  logic [2:0] ss_sync_ff;
  logic [1:0] dir_sync_ff;
  logic [1:0] as_sync_ff;
  logic [1:0] ds_sync_ff;
  logic hw_rst, soft_rst, rst_all;
  logic wb_req, wr_cmd, wr_mode, wr_in, rd_out;
  logic pin_rise, pin_fall;
  logic in_flag_primary;
  logic fifo_in_ready, fifo_out_valid, fifo_push, fifo_pop, fifo_flush;
  logic [7:0] fifo_out_data;
  logic [7:0] fifo_push_data;
  function automatic logic is_reg(input logic [4:0] adr,
                                  input logic [4:0] reg_adr);
    is_reg = (adr[4:2] == reg_adr[4:2]) && (adr[1:0] == 2'b00);
  endfunction
  assign wb_req = wb_cyc_i && wb_stb_i && !ack_ff;
  assign wr_cmd = wb_req && wb_we_i && wb_sel_i[0] &&
                  is_reg(wb_adr_i, ADR_CMD);
  assign wr_mode = wb_req && wb_we_i && wb_sel_i[0] &&
                   is_reg(wb_adr_i, ADR_MODE);
  assign wr_in = wb_req && wb_we_i && wb_sel_i[0] &&
                 is_reg(wb_adr_i, ADR_DATA_IN);
  assign rd_out = wb_req && !wb_we_i && is_reg(wb_adr_i, ADR_DATA_OUT);
  // Strobe pins pass two flops; both low means hardware reset.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ss_sync_ff <= '0;
      dir_sync_ff <= '0;
      as_sync_ff <= 2'b11;
      ds_sync_ff <= 2'b11;
    end else begin
      ss_sync_ff <= {ss_sync_ff[1:0], start_stop_pin_i};
      dir_sync_ff <= {dir_sync_ff[0], direction_select_pin_i};
      as_sync_ff <= {as_sync_ff[0], host_address_strobe_n_i};
      ds_sync_ff <= {ds_sync_ff[0], host_data_strobe_n_i};
    end
  end
  assign hw_rst = !as_sync_ff[1] && !ds_sync_ff[1];
  assign soft_rst = wr_cmd && (wb_dat_i[7:0] == CMD_SW_RESET);
  assign rst_all = rst_i || hw_rst || soft_rst;
  assign pin_rise = direct_mode_i && ss_sync_ff[1] && !ss_sync_ff[2];
  assign pin_fall = direct_mode_i && !ss_sync_ff[1] && ss_sync_ff[2];

  // Bus answer: one cycle after the request, released the cycle after.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_ff <= 1'b0;
      rdat_ff <= '0;
    end else begin
      ack_ff <= wb_req;
      rdat_ff <= '0;
      if (wb_req && !wb_we_i) begin
        if (is_reg(wb_adr_i, ADR_STATUS)) begin
          rdat_ff <= {24'h0, run_state_bit_ff, pending_status_bit_ff,
                      busy_status_bit_ff, 5'h00};
        end else if (is_reg(wb_adr_i, ADR_MODE)) begin
          rdat_ff <= {24'h0, mode_ff};
        end else if (rd_out) begin
          rdat_ff <= {24'h0, fifo_out_valid ? fifo_out_data : 8'h00};
        end
      end
    end
  end
  assign wb_ack_o = ack_ff;
  assign wb_dat_o = rdat_ff;

  // Mode register, with direction forced by start encrypt/decrypt commands and the start pin.
  always_ff @(posedge clk_i) begin
    if (rst_all) begin
      mode_ff <= MODE_RESET;
    end else if (wr_mode) begin
      mode_ff <= wb_dat_i[7:0];
    end else if (wr_cmd && wb_dat_i[7:0] == CMD_START_ENC) begin
      mode_ff[MODE_DIR] <= 1'b1;
    end else if (wr_cmd && wb_dat_i[7:0] == CMD_START_DEC) begin
      mode_ff[MODE_DIR] <= 1'b0;
    end else if (pin_rise) begin
      mode_ff[MODE_DIR] <= dir_sync_ff[1];
    end
  end

  // Run bit from start and stop commands or the start/stop pin.
  always_ff @(posedge clk_i) begin
    if (rst_all) begin
      run_state_bit_ff <= 1'b0;
    end else if (wr_cmd && (wb_dat_i[7:0] == CMD_START_ENC ||
                 wb_dat_i[7:0] == CMD_START_DEC ||
                 wb_dat_i[7:0] == CMD_START)) begin
      run_state_bit_ff <= 1'b1;
    end else if (pin_rise) begin
      run_state_bit_ff <= 1'b1;
    end else if ((wr_cmd && wb_dat_i[7:0] == CMD_STOP) || pin_fall) begin
      run_state_bit_ff <= 1'b0;
    end
  end

  // Port flag tied to the input register follows the direction and routing.
  always_comb begin
    unique case ({mode_ff[MODE_DIR], mode_ff[MODE_PORT_HI:MODE_PORT_LO]})
      3'b001: in_flag_primary = 1'b0;
      3'b100: in_flag_primary = 1'b0;
      default: in_flag_primary = 1'b1;
    endcase
  end
  assign primary_port_flag_n_o = !(run_state_bit_ff && in_flag_primary &&
                                   fifo_in_ready);
  assign secondary_port_flag_n_o = !(run_state_bit_ff && !in_flag_primary &&
                                     fifo_in_ready);
  assign busy_output_pin_n_o = !busy_status_bit_ff;

  // Command engine.
  always_ff @(posedge clk_i) begin
    if (rst_all) begin
      state_ff <= ST_IDLE;
      cmd_ff <= '0;
      pending_status_bit_ff <= 1'b0;
      busy_status_bit_ff <= 1'b0;
      blk_ff <= '0;
      cnt_ff <= '0;
      dly_ff <= '0;
      start_ff <= 1'b0;
      key_ff <= KEY_DEC;
      dec_ff <= 1'b0;
    end else begin
      start_ff <= 1'b0;
      unique case (state_ff)
        ST_IDLE: begin
          if (wr_cmd) begin
            cmd_ff <= wb_dat_i[7:0];
            cnt_ff <= '0;
            unique case (wb_dat_i[7:0])
              CMD_LOAD_ENC_IVE, CMD_LOAD_ENC_IVD, CMD_ENC_MASTER: begin
                pending_status_bit_ff <= 1'b1;
                state_ff <= ST_COLLECT;
              end
              CMD_READ_CLR_IVE, CMD_READ_CLR_IVD: begin
                pending_status_bit_ff <= 1'b1;
                blk_ff <= wb_dat_i[0] ? encrypt_init_vector_ff
                                      : decrypt_init_vector_ff;
                dly_ff <= READ_DELAY_CYC - 4'h2;
                state_ff <= ST_WAIT;
              end
              CMD_READ_ENC_IVE, CMD_READ_ENC_IVD: begin
                pending_status_bit_ff <= 1'b1;
                busy_status_bit_ff <= 1'b1;
                blk_ff <= wb_dat_i[0] ? encrypt_init_vector_ff
                                      : decrypt_init_vector_ff;
                key_ff <= KEY_ENC;
                dec_ff <= 1'b0;
                start_ff <= 1'b1;
                state_ff <= ST_CIPHER;
              end
              default: state_ff <= ST_IDLE;
            endcase
          end
        end
        ST_COLLECT: begin
          if (wr_in) begin
            blk_ff <= {blk_ff[55:0], wb_dat_i[7:0]};
            cnt_ff <= cnt_ff + 4'h1;
            if (cnt_ff == BLOCK_BYTES - 4'h1) begin
              start_ff <= 1'b1;
              state_ff <= ST_CIPHER;
              if (cmd_ff == CMD_ENC_MASTER) begin
                key_ff <= KEY_MASTER;
                dec_ff <= 1'b0;
                busy_status_bit_ff <= 1'b1;
              end else begin
                key_ff <= KEY_DEC;
                dec_ff <= 1'b1;
              end
            end
          end
        end
        ST_CIPHER: begin
          if (cif.done) begin
            busy_status_bit_ff <= 1'b0;
            blk_ff <= cif.dout;
            cnt_ff <= '0;
            if (cmd_ff == CMD_LOAD_ENC_IVE || cmd_ff == CMD_LOAD_ENC_IVD) begin
              pending_status_bit_ff <= 1'b0;
              state_ff <= ST_IDLE;
            end else begin
              state_ff <= ST_DRAIN;
            end
          end
        end
        ST_WAIT: begin
          dly_ff <= dly_ff - 4'h1;
          if (dly_ff == 4'h0) begin
            state_ff <= ST_DRAIN;
          end
        end
        ST_DRAIN: begin
          if (fifo_push) begin
            blk_ff <= {blk_ff[55:0], 8'h00};
            cnt_ff <= cnt_ff + 4'h1;
          end
          if (cnt_ff == BLOCK_BYTES && !fifo_out_valid) begin
            pending_status_bit_ff <= 1'b0;
            state_ff <= ST_IDLE;
          end
        end
        default: state_ff <= ST_IDLE;
      endcase
    end
  end

  // Vector registers take the decrypted block with no parity check.
  always_ff @(posedge clk_i) begin
    if (rst_all) begin
      encrypt_init_vector_ff <= '0;
      decrypt_init_vector_ff <= '0;
    end else if (state_ff == ST_CIPHER && cif.done) begin
      if (cmd_ff == CMD_LOAD_ENC_IVE) begin
        encrypt_init_vector_ff <= cif.dout;
      end
      if (cmd_ff == CMD_LOAD_ENC_IVD) begin
        decrypt_init_vector_ff <= cif.dout;
      end
    end
  end

  assign cif.start = start_ff;
  assign cif.key_sel = key_ff;
  assign cif.decrypt = dec_ff;
  assign cif.din = blk_ff;

  assign fifo_push = (state_ff == ST_DRAIN) && (cnt_ff != BLOCK_BYTES) &&
                     fifo_in_ready;
  assign fifo_push_data = blk_ff[63:56];
  assign fifo_pop = rd_out;
  assign fifo_flush = rst_all;

  ccs_cipher_core u_core (
    .clk_i(clk_i),
    .rst_i(rst_all),
    .key_m_i(key_m_i),
    .key_e_i(key_e_i),
    .key_d_i(key_d_i),
    .core(cif)
  );

  ccs_fifo #(
    .WIDTH(FIFO_WIDTH),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .flush_i(fifo_flush),
    .in_valid_i(fifo_push),
    .in_ready_o(fifo_in_ready),
    .in_data_i(fifo_push_data),
    .out_valid_o(fifo_out_valid),
    .out_ready_i(fifo_pop),
    .out_data_o(fifo_out_data)
  );

  default clocking @(posedge clk_i);
  endclocking
  AST_LOAD_NO_BUSY: assert property (disable iff (rst_i)
    (state_ff != ST_IDLE && (cmd_ff == CMD_LOAD_ENC_IVE ||
     cmd_ff == CMD_LOAD_ENC_IVD)) |-> !busy_status_bit_ff)
    else $error("Busy set during vector load");
  AST_LOAD_PEND: assert property (disable iff (rst_all)
    (wr_cmd && state_ff == ST_IDLE && wb_dat_i[7:0] == CMD_LOAD_ENC_IVE)
    |=> pending_status_bit_ff)
    else $error("Pending not set on vector load");
  AST_CLR_FIRST: assert property (disable iff (rst_all)
    (wr_cmd && state_ff == ST_IDLE && wb_dat_i[7:0] == CMD_READ_CLR_IVE)
    |=> !fifo_out_valid [*6] ##1 fifo_out_valid)
    else $error("First clear byte not ready in time");
  AST_ENC_BUSY: assert property (disable iff (rst_all)
    (wr_cmd && state_ff == ST_IDLE && wb_dat_i[7:0] == CMD_READ_ENC_IVE)
    |=> busy_status_bit_ff && pending_status_bit_ff)
    else $error("Busy or pending missing on encrypted read");
  AST_BUSY_DONE: assert property (disable iff (rst_all)
    (state_ff == ST_CIPHER && cif.done) |=> !busy_status_bit_ff)
    else $error("Busy not cleared after cipher");
  AST_START_RUN: assert property (disable iff (rst_all)
    (wr_cmd && wb_dat_i[7:0] == CMD_START_ENC)
    |=> run_state_bit_ff && mode_ff[MODE_DIR])
    else $error("Start encryption failed");
  AST_STOP_FLAG: assert property (disable iff (rst_all)
    (wr_cmd && wb_dat_i[7:0] == CMD_STOP && !pin_rise)
    |=> primary_port_flag_n_o && secondary_port_flag_n_o)
    else $error("Input flag active after stop");
  AST_PIN_STOP: assert property (disable iff (rst_all)
    pin_fall && !wr_cmd |=> !run_state_bit_ff)
    else $error("Pin fall did not stop");
  AST_SW_RESET: assert property (disable iff (rst_i)
    soft_rst |=> mode_ff == MODE_RESET && !pending_status_bit_ff)
    else $error("Software reset incomplete");
  COV_ENC_READ: cover property (@(posedge clk_i)
    state_ff == ST_DRAIN && cmd_ff == CMD_READ_ENC_IVD);
  COV_MASTER: cover property (@(posedge clk_i)
    state_ff == ST_CIPHER && cmd_ff == CMD_ENC_MASTER);
  COV_PIN_START: cover property (@(posedge clk_i) pin_rise);
endmodule
`default_nettype wire

//--- logic/ccs_pkg.sv
// Package with the constants of the cipher command sequencer.
`default_nettype none
package ccs_pkg;
  localparam logic [7:0] CMD_LOAD_ENC_IVE = 8'hA5;
  localparam logic [7:0] CMD_LOAD_ENC_IVD = 8'hA4;
  localparam logic [7:0] CMD_READ_CLR_IVE = 8'h8D;
  localparam logic [7:0] CMD_READ_CLR_IVD = 8'h8C;
  localparam logic [7:0] CMD_READ_ENC_IVE = 8'hA9;
  localparam logic [7:0] CMD_READ_ENC_IVD = 8'hA8;
  localparam logic [7:0] CMD_ENC_MASTER = 8'h39;
  localparam logic [7:0] CMD_START_ENC = 8'h41;
  localparam logic [7:0] CMD_START_DEC = 8'h40;
  localparam logic [7:0] CMD_START = 8'hC0;
  localparam logic [7:0] CMD_STOP = 8'hE0;
  localparam logic [7:0] CMD_SW_RESET = 8'h00;
  localparam logic [4:0] ADR_CMD = 5'h00;
  localparam logic [4:0] ADR_STATUS = 5'h04;
  localparam logic [4:0] ADR_MODE = 5'h08;
  localparam logic [4:0] ADR_DATA_IN = 5'h0C;
  localparam logic [4:0] ADR_DATA_OUT = 5'h10;
  localparam int STATUS_RUN = 7;
  localparam int STATUS_PEND = 6;
  localparam int STATUS_BUSY = 5;
  localparam int MODE_DIR = 4;
  localparam int MODE_PORT_HI = 3;
  localparam int MODE_PORT_LO = 2;
  localparam logic [7:0] MODE_RESET = 8'h00;
  localparam int READ_DELAY_NS = 120;
  localparam int CLK_PERIOD_NS = 20;
  localparam logic [3:0] READ_DELAY_CYC =
    4'((READ_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [3:0] CIPHER_CYC = 4'h8;
  localparam logic [3:0] BLOCK_BYTES = 4'h8;
  localparam int FIFO_WIDTH = 8;
  localparam int FIFO_DEPTH = 16;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_COLLECT = 3'b001,
    ST_CIPHER = 3'b010,
    ST_WAIT = 3'b011,
    ST_DRAIN = 3'b100
  } ccs_state_t;
  typedef enum logic [1:0] {
    KEY_DEC = 2'b00,
    KEY_ENC = 2'b01,
    KEY_MASTER = 2'b10
  } ccs_key_t;
endpackage
`default_nettype wire

//--- logic/ccs_core_if.sv
// Interface between the sequencer and its block cipher stand-in.
`default_nettype none
interface ccs_core_if;
  logic start;
  logic [1:0] key_sel;
  logic decrypt;
  logic [63:0] din;
  logic done;
  logic [63:0] dout;
  modport seq (output start, output key_sel, output decrypt, output din,
    input done, input dout);
  modport core (input start, input key_sel, input decrypt, input din,
    output done, output dout);
endinterface
`default_nettype wire

//--- logic/ccs_fifo.sv
// Byte FIFO with valid and ready on both sides.
`default_nettype none
module ccs_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic flush_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ff;
  logic [AW-1:0] rd_ff;
  logic [AW:0] cnt_ff;
  logic push;
  logic pop;
  assign in_ready_o = (cnt_ff != (AW+1)'(DEPTH));
  assign out_valid_o = (cnt_ff != '0);
  assign out_data_o = mem[rd_ff];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wr_ff] <= in_data_i;
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i || flush_i) begin
      wr_ff <= '0;
      rd_ff <= '0;
      cnt_ff <= '0;
    end else begin
      wr_ff <= push ? wr_ff + 1'b1 : wr_ff;
      rd_ff <= pop ? rd_ff + 1'b1 : rd_ff;
      cnt_ff <= cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
  AST_FIFO_NO_OVER: assert property (@(posedge clk_i) disable iff (rst_i)
    cnt_ff <= (AW+1)'(DEPTH))
    else $error("FIFO count above depth");
endmodule
`default_nettype wire

//--- logic/ccs_cipher_core.sv
// Stand-in cipher unit: fixed latency keyed mixing of one block.
`default_nettype none
module ccs_cipher_core
  import ccs_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [63:0] key_m_i,
  input wire logic [63:0] key_e_i,
  input wire logic [63:0] key_d_i,
  ccs_core_if.core core
);
  logic [3:0] cnt_ff;
  logic [63:0] acc_ff;
  logic run_ff;
  logic done_ff;
  logic [63:0] key;
  always_comb begin
    key = key_d_i;
    unique case (core.key_sel)
      KEY_ENC: key = key_e_i;
      KEY_MASTER: key = key_m_i;
      default: key = key_d_i;
    endcase
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_ff <= '0;
      run_ff <= 1'b0;
      done_ff <= 1'b0;
      acc_ff <= '0;
    end else begin
      done_ff <= 1'b0;
      if (core.start) begin
        run_ff <= 1'b1;
        cnt_ff <= CIPHER_CYC;
        acc_ff <= core.din;
      end else if (run_ff) begin
        acc_ff <= core.decrypt ? {acc_ff[0], acc_ff[63:1]} ^ key
                               : {acc_ff[62:0], acc_ff[63]} ^ key;
        cnt_ff <= cnt_ff - 1'b1;
        if (cnt_ff == 4'h1) begin
          run_ff <= 1'b0;
          done_ff <= 1'b1;
        end
      end
    end
  end
  assign core.done = done_ff;
  assign core.dout = acc_ff;
endmodule
`default_nettype wire

//--- verif/ccs_host_model.sv
// Wishbone host model that issues command, status and data transfers.
`default_nettype none
module ccs_host_model (
  input wire logic clk_i,
  input wire logic wb_ack_i,
  input wire logic [31:0] wb_dat_i,
  output logic wb_cyc_o,
  output logic wb_stb_o,
  output logic wb_we_o,
  output logic [4:0] wb_adr_o,
  output logic [3:0] wb_sel_o,
  output logic [31:0] wb_dat_o
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    wb_cyc_o = 1'b0;
    wb_stb_o = 1'b0;
    wb_we_o = 1'b0;
    wb_adr_o = 5'h00;
    wb_sel_o = 4'h0;
    wb_dat_o = 32'h0;
  end
  // One classic cycle held until ack is sampled, then one idle cycle.
  // Each command is one byte written to the command address.
  task automatic xfer(input logic we, input logic [4:0] adr,
                      input logic [7:0] d, output logic [7:0] q);
    wb_cyc_o <= 1'b1;
    wb_stb_o <= 1'b1;
    wb_we_o <= we;
    wb_adr_o <= adr;
    wb_sel_o <= 4'hF;
    wb_dat_o <= {24'h0, d};
    do begin
      @(posedge clk_i);
    end while (wb_ack_i !== 1'b1);
    q = wb_dat_i[7:0];
    wb_cyc_o <= 1'b0;
    wb_stb_o <= 1'b0;
    wb_we_o <= 1'b0;
    wb_dat_o <= ~wb_dat_o;
    @(posedge clk_i);
  endtask
endmodule
`default_nettype wire

//--- verif/ccs_sequencer_bench.sv
// Self-checking bench for the cipher command sequencer.
`default_nettype none
module ccs_sequencer_bench
  import ccs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [4:0] A_CMD = 5'h00;
  localparam logic [4:0] A_STAT = 5'h04;
  localparam logic [4:0] A_MODE = 5'h08;
  localparam logic [4:0] A_IN = 5'h0C;
  localparam logic [4:0] A_OUT = 5'h10;
  typedef struct packed {
    logic [7:0] mode;
    logic [7:0] cmd;
    logic run;
    logic dir;
    logic pf_n;
    logic sf_n;
  } ccs_row_t;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc, stb, we, ack, dm, ssp, dsp, as_n, ds_n;
  logic pflag_n, sflag_n, busy_n;
  logic [4:0] adr;
  logic [3:0] sel;
  logic [31:0] wdat, rdat;
  logic [7:0] q;
  logic [63:0] blk, ref_blk;
  int error_cnt = 0;
  int n_checks = 0;
  int cycles = 0;
  ccs_row_t rows [9];
  always #10 clk_i = ~clk_i;
  initial begin
    dm = 1'b0;
    ssp = 1'b0;
    dsp = 1'b0;
    as_n = 1'b1;
    ds_n = 1'b1;
  end
  ccs_host_model host (.clk_i(clk_i), .wb_ack_i(ack), .wb_dat_i(rdat),
    .wb_cyc_o(cyc), .wb_stb_o(stb), .wb_we_o(we), .wb_adr_o(adr),
    .wb_sel_o(sel), .wb_dat_o(wdat));
  ccs_sequencer uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .direct_mode_i(dm), .start_stop_pin_i(ssp),
    .direction_select_pin_i(dsp), .host_address_strobe_n_i(as_n),
    .host_data_strobe_n_i(ds_n), .key_m_i(64'h0123456789ABCDEF),
    .key_e_i(64'h13579BDF02468ACE), .key_d_i(64'hFEDCBA9876543210),
    .primary_port_flag_n_o(pflag_n), .secondary_port_flag_n_o(sflag_n),
    .busy_output_pin_n_o(busy_n));
  task automatic close_out();
    if (error_cnt == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      error_cnt++;
      close_out();
    end
  end
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  // Reads status until the bit shows the wanted value, bounded.
  task automatic poll(input int b, input logic v);
    int n;
    n = 0;
    do begin
      host.xfer(1'b0, A_STAT, 8'h00, q);
      n++;
    end while (q[b] !== v && n < 40);
    chk(q[b], v);
  endtask
  task automatic chk_def();
    host.xfer(1'b0, A_MODE, 8'h00, q);
    chk(q, MODE_RESET);
    host.xfer(1'b0, A_STAT, 8'h00, q);
    chk(q, 8'h00);
    chk({pflag_n, sflag_n, busy_n}, 3'b111);
  endtask
  // Reads eight bytes, first byte most significant, then checks that a ninth read returns zero.
  task automatic read8(output logic [63:0] b);
    for (int k = 0; k < 8; k++) begin
      host.xfer(1'b0, A_OUT, 8'h00, q);
      b = {b[55:0], q};
      if (k < 7) begin
        host.xfer(1'b0, A_STAT, 8'h00, q);
        chk(q[STATUS_PEND], 1'b1);
      end
    end
    poll(STATUS_PEND, 1'b0);
    host.xfer(1'b0, A_OUT, 8'h00, q);
    chk(q, 8'h00);
  endtask
  task automatic cmd_w(input logic [7:0] c);
    host.xfer(1'b1, A_CMD, c, q);
  endtask
  task automatic write8(input logic [7:0] base);
    for (int k = 0; k < 8; k++) begin
      host.xfer(1'b1, A_IN, base + 8'(k), q);
    end
  endtask
  initial begin
    rows[0] = '{8'h00, CMD_START_ENC, 1'b1, 1'b1, 1'b1, 1'b0};
    rows[1] = '{8'h10, CMD_STOP, 1'b0, 1'b1, 1'b1, 1'b1};
    rows[2] = '{8'h00, CMD_START_DEC, 1'b1, 1'b0, 1'b0, 1'b1};
    rows[3] = '{8'h00, CMD_STOP, 1'b0, 1'b0, 1'b1, 1'b1};
    rows[4] = '{8'h10, CMD_START, 1'b1, 1'b1, 1'b1, 1'b0};
    rows[5] = '{8'h10, CMD_STOP, 1'b0, 1'b1, 1'b1, 1'b1};
    rows[6] = '{8'h04, CMD_START, 1'b1, 1'b0, 1'b1, 1'b0};
    rows[7] = '{8'h04, CMD_STOP, 1'b0, 1'b0, 1'b1, 1'b1};
    rows[8] = '{8'h18, CMD_START_DEC, 1'b1, 1'b0, 1'b0, 1'b1};
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk_def();
    foreach (rows[i]) begin
      host.xfer(1'b1, A_MODE, rows[i].mode, q);
      cmd_w(rows[i].cmd);
      host.xfer(1'b0, A_STAT, 8'h00, q);
      chk(q[STATUS_RUN], rows[i].run);
      host.xfer(1'b0, A_MODE, 8'h00, q);
      chk(q[MODE_DIR], rows[i].dir);
      chk({pflag_n, sflag_n}, {rows[i].pf_n, rows[i].sf_n});
    end
    cmd_w(CMD_SW_RESET);
    chk_def();
    host.xfer(1'b1, A_MODE, 8'h10, q);
    cmd_w(CMD_START);
    as_n <= 1'b0;
    ds_n <= 1'b0;
    repeat (4) @(posedge clk_i);
    as_n <= 1'b1;
    ds_n <= 1'b1;
    repeat (4) @(posedge clk_i);
    chk_def();
    for (int j = 0; j < 3; j++) begin
      cmd_w(j == 1 ? CMD_READ_CLR_IVD : CMD_READ_CLR_IVE);
      host.xfer(1'b0, A_STAT, 8'h00, q);
      chk(q[STATUS_PEND], 1'b1);
      repeat (4) @(posedge clk_i);
      read8(blk);
      if (j == 0) ref_blk = blk;
    end
    chk(blk, ref_blk);
    for (int j = 0; j < 2; j++) begin
      cmd_w(j == 0 ? CMD_LOAD_ENC_IVE : CMD_LOAD_ENC_IVD);
      host.xfer(1'b0, A_STAT, 8'h00, q);
      chk(q[STATUS_PEND], 1'b1);
      write8(8'h30 + 8'(j * 16));
      host.xfer(1'b0, A_STAT, 8'h00, q);
      chk(q[STATUS_BUSY], 1'b0);
      poll(STATUS_PEND, 1'b0);
      cmd_w(CMD_READ_CLR_IVE);
      repeat (4) @(posedge clk_i);
      read8(blk);
      if (j == 0) ref_blk = blk;
    end
    chk(blk, ref_blk);
    cmd_w(CMD_READ_CLR_IVD);
    repeat (4) @(posedge clk_i);
    read8(blk);
    chk(blk != ref_blk, 1'b1);
    foreach (rows[i]) begin
      if (i < 3) begin
        cmd_w(i == 0 ? CMD_ENC_MASTER :
              (i == 1 ? CMD_READ_ENC_IVE : CMD_READ_ENC_IVD));
        host.xfer(1'b0, A_STAT, 8'h00, q);
        chk(q[STATUS_PEND], 1'b1);
        if (i == 0) begin
          chk(q[STATUS_BUSY], 1'b0);
          write8(8'hA0);
        end
        poll(STATUS_BUSY, 1'b1);
        poll(STATUS_BUSY, 1'b0);
        chk(q[STATUS_PEND], 1'b1);
        read8(blk);
        if (i == 1) ref_blk = blk;
        if (i == 2) chk(blk != ref_blk, 1'b1);
      end
    end
    dm <= 1'b1;
    for (int d = 1; d >= 0; d--) begin
      dsp <= d[0];
      repeat (4) @(posedge clk_i);
      ssp <= 1'b1;
      poll(STATUS_RUN, 1'b1);
      host.xfer(1'b0, A_MODE, 8'h00, q);
      chk(q[MODE_DIR], d[0]);
      chk({pflag_n, sflag_n}, {d[0], ~d[0]});
      ssp <= 1'b0;
      poll(STATUS_RUN, 1'b0);
      chk({pflag_n, sflag_n}, 2'b11);
    end
    close_out();
  end
endmodule
`default_nettype wire
